// file: common/sfe_pkg.sv
// Purpose: Shared constants for the serial flash front end
// Assumes: 8-bit bus cycles, 24-bit addresses, 4 Mbit array
// Notes: Status bit positions and power-up values live here
`default_nettype none
package sfe_pkg;
	localparam int BYTE_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int ARRAY_ADDR_BITS = 19;
	localparam int SECTOR_BYTES = 4096;
	localparam int BLOCK_BYTES = 32768;
	localparam int SECTOR_SHIFT = $clog2(SECTOR_BYTES);
	localparam int BLOCK_SHIFT = $clog2(BLOCK_BYTES);
	localparam int SECTOR_IDX_W = ARRAY_ADDR_BITS - SECTOR_SHIFT;
	localparam int BLOCK_IDX_W = ARRAY_ADDR_BITS - BLOCK_SHIFT;

	// Status register layout
	localparam int SR_BUSY_BIT = 0;
	localparam int SR_WLATCH_BIT = 1;
	localparam int SR_LVL_LO_BIT = 2;
	localparam int SR_LVL_HI_BIT = 3;
	localparam int SR_AUTOINC_BIT = 6;
	localparam int SR_LOCK_BIT = 7;
	localparam logic [1:0] LEVEL_RESET = 2'h3;
	localparam logic LOCK_RESET = 1'h0;

	// Position of a byte inside a command sequence
	localparam logic [2:0] IDX_OPCODE = 3'h0;
	localparam logic [2:0] IDX_FIRST_DATA = 3'h1;
	localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
	localparam logic [2:0] IDX_SAT = 3'h4;
	localparam logic [2:0] BIT_LAST = 3'h7;

	function automatic logic [SECTOR_IDX_W-1:0] sector_of(input logic [ADDR_BITS-1:0] addr);
		return addr[SECTOR_SHIFT +: SECTOR_IDX_W];
	endfunction

	function automatic logic [BLOCK_IDX_W-1:0] block_of(input logic [ADDR_BITS-1:0] addr);
		return addr[BLOCK_SHIFT +: BLOCK_IDX_W];
	endfunction
endpackage
`default_nettype wire

// file: hw/sfe_sync.sv
// Purpose: Two-flop synchroniser for the serial pins
// Assumes: Inputs are asynchronous to clock
// Notes: Only the second stage is visible outside
`timescale 1ns/10ps
`default_nettype none
module sfe_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;

	initial begin
		if (WIDTH < 1) begin
			$error("sfe_sync needs WIDTH of at least one");
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			stage1 <= INIT;
			dout <= INIT;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule
`default_nettype wire

// file: hw/sfe_status.sv
// Purpose: Status register with protection level and lock bits
// Assumes: Write requests arrive as one-cycle pulses on clock
// Notes: Busy, write latch and auto-increment come from the engines
`timescale 1ns/10ps
`default_nettype none
module sfe_status (
	input wire logic clock,
	input wire logic rst,
	input wire logic wpSync,
	input wire logic wrReq,
	input wire logic [7:0] wrData,
	input wire logic busy,
	input wire logic writeLatch,
	input wire logic autoInc,
	output logic [7:0] statusByte,
	output logic [1:0] protectLevel,
	output logic protectLock,
	output logic wrDone,
	output logic wrRejected
);
	logic allowed;

	// Lock only bites while the write-protect pin is low
	assign allowed = wpSync || !protectLock;

	always_ff @(posedge clock) begin
		if (rst) begin
			protectLevel <= sfe_pkg::LEVEL_RESET;
			protectLock <= sfe_pkg::LOCK_RESET;
		end else if (wrReq && allowed) begin
			protectLevel <= {wrData[sfe_pkg::SR_LVL_HI_BIT], wrData[sfe_pkg::SR_LVL_LO_BIT]};
			protectLock <= wrData[sfe_pkg::SR_LOCK_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			wrDone <= 1'h0;
			wrRejected <= 1'h0;
		end else begin
			wrDone <= wrReq && allowed;
			wrRejected <= wrReq && !allowed;
		end
	end

	always_comb begin
		statusByte = 8'h00;
		statusByte[sfe_pkg::SR_BUSY_BIT] = busy;
		statusByte[sfe_pkg::SR_WLATCH_BIT] = writeLatch;
		statusByte[sfe_pkg::SR_LVL_LO_BIT] = protectLevel[0];
		statusByte[sfe_pkg::SR_LVL_HI_BIT] = protectLevel[1];
		statusByte[sfe_pkg::SR_AUTOINC_BIT] = autoInc;
		statusByte[sfe_pkg::SR_LOCK_BIT] = protectLock;
	end

	a_lock_reject: assert property (@(posedge clock) disable iff (rst)
		(wrReq && !wpSync && protectLock) |=> (wrRejected && $stable(protectLevel) && protectLock))
		else $error("locked status write was not rejected");

	a_write_allow: assert property (@(posedge clock) disable iff (rst)
		(wrReq && (wpSync || !protectLock)) |=>
		(wrDone && protectLevel == $past({wrData[sfe_pkg::SR_LVL_HI_BIT], wrData[sfe_pkg::SR_LVL_LO_BIT]})
		&& protectLock == $past(wrData[sfe_pkg::SR_LOCK_BIT])))
		else $error("allowed status write did not take effect");
endmodule
`default_nettype wire

// file: hw/sfe_front_end.sv
// Purpose: Serial peripheral slave front end of a serial flash
// Assumes: Pins are asynchronous; clock is much faster than the serial clock
// Notes: Bytes, addresses and status writes are handed to the engines as pulses
`timescale 1ns/10ps
`default_nettype none
module sfe_front_end #(
	parameter logic [7:0] STATUS_WRITE_OP = 8'h01,
	parameter logic [7:0] STATUS_READ_OP = 8'h05
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic selN,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic holdN,
	input wire logic wpN,
	output logic miso,
	output logic misoOe,
	input wire logic busy,
	input wire logic writeLatch,
	input wire logic autoInc,
	input wire logic txActive,
	input wire logic [7:0] txByte,
	output logic txNext,
	output logic seqStart,
	output logic seqAbort,
	output logic rxValid,
	output logic [7:0] rxByte,
	output logic [2:0] rxIndex,
	output logic addrValid,
	output logic [sfe_pkg::ADDR_BITS-1:0] address,
	output logic [sfe_pkg::SECTOR_IDX_W-1:0] sectorIndex,
	output logic [sfe_pkg::BLOCK_IDX_W-1:0] blockIndex,
	output logic paused,
	output logic [7:0] statusByte,
	output logic [1:0] protectLevel,
	output logic protectLock,
	output logic statusWriteDone,
	output logic statusWriteRejected
);
	logic selSync, sclkSync, mosiSync, holdSync, wpSync;
	logic selPrev, sclkPrev;
	logic active, rise, fall, byteEnd;
	logic [2:0] bitCnt;
	logic [2:0] byteCnt;
	logic [7:0] rxShift;
	logic [7:0] rxFull;
	logic [7:0] opcode;
	logic statusMode;
	logic nextStatusMode;
	logic [7:0] txShift;
	logic txOn;
	logic misoOeReg;
	logic statusWrReq;

	initial begin
		if (sfe_pkg::BLOCK_SHIFT <= sfe_pkg::SECTOR_SHIFT) begin
			$error("block must be larger than sector");
		end
	end

	// Select and pause idle high, so they reset to the idle level
	sfe_sync #(
		.WIDTH(5),
		.INIT(5'h19)
	) u_sync (
		.clock(clock),
		.rst(rst),
		.din({selN, holdN, wpN, sclk, mosi}),
		.dout({selSync, holdSync, wpSync, sclkSync, mosiSync})
	);

	always_ff @(posedge clock) begin
		if (rst) begin
			selPrev <= 1'h1;
			sclkPrev <= 1'h0;
		end else begin
			selPrev <= selSync;
			sclkPrev <= sclkSync;
		end
	end

	// Pause changes only while the serial clock is low, except that deselect clears it, so no edge is cut in half
	always_ff @(posedge clock) begin
		if (rst || selSync) begin
			paused <= 1'h0;
		end else if (!sclkSync && !holdSync) begin
			paused <= 1'h1;
		end else if (!sclkSync && holdSync) begin
			paused <= 1'h0;
		end
	end

	// Edges are seen only from the level, so the idle level of either mode is harmless
	assign active = !selSync && !paused;
	assign rise = active && sclkSync && !sclkPrev;
	assign fall = active && !sclkSync && sclkPrev;
	assign byteEnd = rise && bitCnt == sfe_pkg::BIT_LAST;
	assign rxFull = {rxShift[6:0], mosiSync};

	always_ff @(posedge clock) begin
		if (rst) begin
			seqStart <= 1'h0;
			seqAbort <= 1'h0;
		end else begin
			seqStart <= !selSync && selPrev;
			seqAbort <= selSync && !selPrev && (bitCnt != 3'h0 || paused);
		end
	end

	always_ff @(posedge clock) begin
		if (rst || selSync) begin
			bitCnt <= 3'h0;
			byteCnt <= sfe_pkg::IDX_OPCODE;
			rxShift <= 8'h00;
		end else if (rise) begin
			rxShift <= rxFull;
			bitCnt <= bitCnt + 3'h1;
			if (byteEnd && byteCnt != sfe_pkg::IDX_SAT) begin
				byteCnt <= byteCnt + 3'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rxValid <= 1'h0;
			rxByte <= 8'h00;
			rxIndex <= 3'h0;
		end else begin
			rxValid <= byteEnd;
			if (byteEnd) begin
				rxByte <= rxFull;
				rxIndex <= byteCnt;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			opcode <= 8'h00;
			address <= '0;
			addrValid <= 1'h0;
			sectorIndex <= '0;
			blockIndex <= '0;
		end else begin
			addrValid <= 1'h0;
			if (byteEnd && byteCnt == sfe_pkg::IDX_OPCODE) begin
				opcode <= rxFull;
			end
			if (byteEnd && byteCnt >= sfe_pkg::IDX_FIRST_DATA && byteCnt <= sfe_pkg::IDX_ADDR_LAST) begin
				address <= {address[15:0], rxFull};
			end
			if (byteEnd && byteCnt == sfe_pkg::IDX_ADDR_LAST) begin
				addrValid <= 1'h1;
				sectorIndex <= sfe_pkg::sector_of({address[15:0], rxFull});
				blockIndex <= sfe_pkg::block_of({address[15:0], rxFull});
			end
		end
	end

	// Status data byte acts as soon as its last bit lands
	assign statusWrReq = byteEnd && byteCnt == sfe_pkg::IDX_FIRST_DATA && opcode == STATUS_WRITE_OP;

	sfe_status u_status (
		.clock(clock),
		.rst(rst),
		.wpSync(wpSync),
		.wrReq(statusWrReq),
		.wrData(rxFull),
		.busy(busy),
		.writeLatch(writeLatch),
		.autoInc(autoInc),
		.statusByte(statusByte),
		.protectLevel(protectLevel),
		.protectLock(protectLock),
		.wrDone(statusWriteDone),
		.wrRejected(statusWriteRejected)
	);

	always_comb begin
		nextStatusMode = statusMode;
		if (byteCnt == sfe_pkg::IDX_OPCODE) begin
			nextStatusMode = rxFull == STATUS_READ_OP;
		end
	end

	// Next byte is chosen at the rise that ends the current one
	always_ff @(posedge clock) begin
		if (rst || selSync) begin
			statusMode <= 1'h0;
			txOn <= 1'h0;
			txShift <= 8'h00;
			txNext <= 1'h0;
		end else begin
			txNext <= 1'h0;
			if (byteEnd) begin
				statusMode <= nextStatusMode;
				txOn <= nextStatusMode || txActive;
				txShift <= nextStatusMode ? statusByte : txByte;
				txNext <= !nextStatusMode && txActive;
			end else if (fall && txOn) begin
				txShift <= {txShift[6:0], 1'h0};
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			miso <= 1'h0;
		end else if (fall && txOn) begin
			miso <= txShift[7];
		end
	end

	always_ff @(posedge clock) begin
		if (rst || selSync) begin
			misoOeReg <= 1'h0;
		end else if (fall) begin
			misoOeReg <= txOn;
		end
	end

	assign misoOe = misoOeReg && active;

	sequence s_sel_fall;
		!selSync && selPrev;
	endsequence

	sequence s_low_clock_hold;
		active && !sclkSync && !holdSync;
	endsequence

	a_seq_start: assert property (@(posedge clock) disable iff (rst)
		s_sel_fall |=> seqStart ##1 !seqStart)
		else $error("select fall did not give one start pulse");

	a_pause_enter: assert property (@(posedge clock) disable iff (rst)
		s_low_clock_hold |=> paused)
		else $error("pause not entered with clock low");

	a_pause_stay: assert property (@(posedge clock) disable iff (rst)
		(paused && !holdSync && !selSync) |=> paused)
		else $error("pause left while pause input low");

	a_pause_exit: assert property (@(posedge clock) disable iff (rst)
		(paused && holdSync && !sclkSync && !selSync) |=> !paused)
		else $error("pause not left with clock low");

	a_pause_keeps: assert property (@(posedge clock) disable iff (rst)
		(paused && !selSync) |=> ($stable(bitCnt) && $stable(rxShift) && $stable(byteCnt)))
		else $error("shift state moved during pause");

	a_pause_hiz: assert property (@(posedge clock) disable iff (rst)
		paused |-> !misoOe)
		else $error("output driven while paused");

	a_desel_reset: assert property (@(posedge clock) disable iff (rst)
		selSync |=> (bitCnt == 3'h0 && !paused && !misoOeReg && !txOn))
		else $error("deselect did not reset interface");

	a_byte_capture: assert property (@(posedge clock) disable iff (rst)
		byteEnd |=> (rxValid && rxByte == $past(rxFull) && rxIndex == $past(byteCnt)))
		else $error("received byte wrong");

	a_miso_on_fall: assert property (@(posedge clock) disable iff (rst)
		!$stable(miso) |-> $past(fall))
		else $error("output changed without a falling edge");

	a_status_send: assert property (@(posedge clock) disable iff (rst)
		(byteEnd && byteCnt == sfe_pkg::IDX_OPCODE && rxFull == STATUS_READ_OP) |=>
		(txOn && txShift == $past(statusByte)))
		else $error("status read did not load status byte");
endmodule
`default_nettype wire

// file: tb/sfe_spi_host.sv
// Purpose: Bus master model driving the serial pins of the front end
// Assumes: Half period of 100 ns; calls start on a falling clock edge
// Notes: Mode chosen by cpol; data line toggles just before each deselect
`timescale 1ns/10ps
`default_nettype none
module sfe_spi_host (
	input wire logic clock,
	output logic selN,
	output logic sclk,
	output logic mosi,
	output logic holdN,
	input wire logic miso
);
	logic cpol;
	initial begin
		selN = 1'h1;
		sclk = 1'h0;
		mosi = 1'h0;
		holdN = 1'h1;
		cpol = 1'h0;
	end
	// Released data line must not look stable
	// Idle clock level settles before select moves, so no false edge
	task automatic sel(input logic v);
		@(negedge clock);
		if (v) mosi = ~mosi;
		sclk = cpol;
		#200;
		selN = v;
		#200;
	endtask
	task automatic xbit(input logic b, output logic r);
		@(negedge clock);
		sclk = 1'h0;
		mosi = b;
		#100;
		sclk = 1'h1;
		#100;
		r = miso;
	endtask
	// Whole bytes, MSB first; mode 0 ends on a fall
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
		if (!cpol) sclk = 1'h0;
		#100;
	endtask
	// Pause entered only while selected; the abort test releases it after deselect
	task automatic hold(input logic v);
		@(negedge clock);
		holdN = v;
		#200;
	endtask
endmodule
`default_nettype wire

// file: tb/sfe_front_end_tb_top.sv
// Purpose: Self-checking bench for the serial flash front end
// Assumes: Host model drives the serial pins, bench drives wpN and engine side
// Notes: Pulses are counted by monitors, judged by checks inside some tests
`timescale 1ns/10ps
`default_nettype none
module sfe_front_end_tb_top;
	logic clock = 1'h0, rst = 1'h1, wpN = 1'h1, busy = 1'h1, writeLatch = 1'h0;
	logic autoInc = 1'h1, txActive = 1'h0;
	logic [7:0] txByte = 8'ha5;
	logic selN, sclk, mosi, holdN, miso, misoOe, txNext, seqStart, seqAbort;
	logic paused, protectLock, statusWriteDone, statusWriteRejected, rxValid, addrValid;
	int rxCnt = 0, addrCnt = 0;
	logic [7:0] rxByte, statusByte, q;
	logic [2:0] rxIndex;
	logic [1:0] protectLevel;
	logic [23:0] address;
	logic [6:0] sectorIndex;
	logic [3:0] blockIndex;
	int bad_count = 0, num_checks = 0, cyc = 0;
	int doneCnt = 0, rejCnt = 0, abortCnt = 0, startCnt = 0, txCnt = 0;
	always #12.5 clock = ~clock;
	sfe_spi_host host (.clock(clock), .selN(selN), .sclk(sclk), .mosi(mosi),
		.holdN(holdN), .miso(misoOe ? miso : 1'hz));
	sfe_front_end uut (.clock(clock), .rst(rst), .selN(selN), .sclk(sclk), .mosi(mosi),
		.holdN(holdN), .wpN(wpN), .miso(miso), .misoOe(misoOe), .busy(busy),
		.writeLatch(writeLatch), .autoInc(autoInc), .txActive(txActive),
		.txByte(txByte), .txNext(txNext), .seqStart(seqStart), .seqAbort(seqAbort),
		.rxValid(rxValid), .rxByte(rxByte), .rxIndex(rxIndex), .addrValid(addrValid),
		.address(address), .sectorIndex(sectorIndex), .blockIndex(blockIndex),
		.paused(paused), .statusByte(statusByte), .protectLevel(protectLevel),
		.protectLock(protectLock), .statusWriteDone(statusWriteDone),
		.statusWriteRejected(statusWriteRejected));
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			print_verdict();
		end
		if (statusWriteDone === 1'h1) doneCnt <= doneCnt + 1;
		if (statusWriteRejected === 1'h1) rejCnt <= rejCnt + 1;
		if (seqAbort === 1'h1) abortCnt <= abortCnt + 1;
		if (seqStart === 1'h1) startCnt <= startCnt + 1;
		if (txNext === 1'h1) txCnt <= txCnt + 1;
		if (rxValid === 1'h1) rxCnt <= rxCnt + 1;
		if (addrValid === 1'h1) addrCnt <= addrCnt + 1;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle();
		repeat (8) @(negedge clock);
	endtask
	task automatic wsr(input logic [7:0] d);
		host.sel(1'h0);
		host.xbyte(8'h01, q);
		host.xbyte(d, q);
		settle();
		host.sel(1'h1);
	endtask
	task automatic t_reset();
		check(24'({protectLevel, protectLock, paused, misoOe}), 24'h18);
		$display("test reset done");
	endtask
	task automatic t_write();
		wsr(8'h84);
		check(24'({rxByte, rxIndex}), 24'h421);
		check(24'({protectLevel, protectLock}), 24'h3);
		@(negedge clock) wpN = 1'h0;
		wsr(8'h00);
		check(24'({protectLevel, protectLock}), 24'h3);
		check(24'(rejCnt), 24'h1);
		@(negedge clock) wpN = 1'h1;
		wsr(8'h00);
		check(24'({protectLevel, protectLock}), 24'h0);
		check(24'(doneCnt), 24'h2);
		$display("test status write done");
	endtask
	task automatic t_read();
		host.cpol = 1'h1;
		@(negedge clock);
		busy = 1'h0;
		writeLatch = 1'h1;
		autoInc = 1'h0;
		host.sel(1'h0);
		host.xbyte(8'h05, q);
		host.xbyte(8'h00, q);
		check(24'(q), 24'h02);
		check(24'({statusByte, misoOe}), 24'h005);
		host.sel(1'h1);
		settle();
		check(24'(misoOe), 24'h0);
		host.cpol = 1'h0;
		$display("test status read done");
	endtask
	task automatic t_hold();
		host.sel(1'h0);
		for (int i = 7; i >= 4; i--) host.xbit(8'ha6 >> i, q[0]);
		host.hold(1'h0);
		check(24'(paused), 24'h0);
		host.xbit(1'h1, q[0]);
		host.xbit(1'h0, q[0]);
		check(24'({paused, misoOe}), 24'h2);
		host.hold(1'h1);
		check(24'(paused), 24'h1);
		for (int i = 3; i >= 0; i--) host.xbit(8'ha6 >> i, q[0]);
		settle();
		check(24'({rxByte, rxIndex, paused}), 24'ha60);
		host.sel(1'h1);
		$display("test pause done");
	endtask
	task automatic t_abort();
		host.sel(1'h0);
		for (int i = 0; i < 3; i++) host.xbit(1'h1, q[0]);
		host.sel(1'h1);
		settle();
		check(24'(abortCnt), 24'h1);
		host.sel(1'h0);
		host.hold(1'h0);
		host.sel(1'h1);
		settle();
		check(24'({abortCnt[3:0], paused}), 24'h4);
		host.hold(1'h1);
		check(24'(startCnt), 24'h7);
		$display("test abort done");
	endtask
	task automatic t_addr();
		@(negedge clock);
		txActive = 1'h1;
		txByte = 8'h3c;
		host.sel(1'h0);
		host.xbyte(8'h03, q);
		host.xbyte(8'h07, q);
		host.xbyte(8'hd0, q);
		host.xbyte(8'h00, q);
		check(address, 24'h07d000);
		check(24'({sectorIndex, blockIndex}), 24'h7df);
		check(24'(addrCnt), 24'h1);
		host.xbyte(8'h00, q);
		check(24'(q), 24'h3c);
		check(24'(txCnt > 0), 24'h1);
		check(24'(rxCnt), 24'he);
		host.sel(1'h1);
		$display("test address done");
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clock);
		rst = 1'h0;
		settle();
		t_reset();
		t_write();
		t_read();
		t_hold();
		t_abort();
		t_addr();
		print_verdict();
	end
endmodule
`default_nettype wire
